// ==== design/mmts_pkg.sv ====
// Constants, state codes and state records of the two-wire management slave
package mmts_pkg;

  localparam logic [6:0] FIRST_DEVICE_ADDRESS = 7'h50;
  localparam logic [6:0] SECOND_DEVICE_ADDRESS = 7'h51;

  localparam int unsigned SYS_PERIOD_NS = 40;
  localparam int unsigned LINK_PERIOD_NS = 80;

  // Short hold after a falling edge, well inside any legal low phase
  localparam int unsigned STRETCH_NS = 400;
  localparam int unsigned STRETCH_CYC = (STRETCH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int unsigned HOLD_MAX_US = 500;
  localparam int unsigned HOLD_MAX_CYC = HOLD_MAX_US * 1000 / LINK_PERIOD_NS;

  localparam int unsigned TWR_SHORT_MS = 40;
  localparam int unsigned TWR_LONG_MS = 80;
  localparam int unsigned TWR_SHORT_CYC = TWR_SHORT_MS * 1000000 / SYS_PERIOD_NS;
  localparam int unsigned TWR_LONG_CYC = TWR_LONG_MS * 1000000 / SYS_PERIOD_NS;
  // Crossing latency taken off the timer so the busy window ends in time
  localparam int unsigned SYNC_MARGIN_CYC = 16;
  localparam int TIMER_W = 22;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] WR_MAX_BYTES = 4'h8;
  localparam logic [3:0] LONG_WRITE_BYTES = 4'h4;
  localparam logic [3:0] STRETCH_LOAD = 4'(STRETCH_CYC);
  localparam logic [3:0] STRETCH_LAST = 4'h1;
  localparam logic [7:0] ADDR_STEP = 8'h01;
  localparam logic [2:0] SYNC_IDLE = 3'h7;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_RX = 7'h02,
    S_ACK = 7'h04,
    S_STRETCH = 7'h08,
    S_TX = 7'h10,
    S_TXACK = 7'h20,
    S_COMMIT = 7'h40
  } mmts_link_state_t;

  typedef enum logic [1:0] {
    SYS_IDLE = 2'h1,
    SYS_TIME = 2'h2
  } mmts_sys_state_t;

  typedef enum logic [1:0] {
    KIND_DEV = 2'h0,
    KIND_MEM = 2'h1,
    KIND_DATA = 2'h2
  } mmts_kind_t;

  typedef struct packed {
    mmts_link_state_t state;
    mmts_kind_t kind;
    logic [2:0] sclSync;
    logic [2:0] sdaSync;
    logic sclLvl;
    logic sdaLvl;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic dev;
    logic readOp;
    logic hostAck;
    logic [1:0][7:0] addrCnt;
    logic wrPending;
    logic [7:0] wrBase;
    logic [3:0] wrCount;
    logic [7:0][7:0] wrBuf;
    logic [3:0] commitIdx;
    logic [3:0] stretchCnt;
    logic sdaOe;
    logic sclOe;
    logic zeroOut;
    logic reqToggle;
    logic longWrite;
    logic [1:0] ackSync;
  } mmts_link_t;

  typedef struct packed {
    mmts_sys_state_t state;
    logic [1:0] reqSync;
    logic [1:0] longSync;
    logic ackToggle;
    logic [TIMER_W-1:0] timer;
  } mmts_sys_t;

  localparam mmts_link_t LINK_RESET = '{state: S_IDLE, kind: KIND_DEV, sclSync: SYNC_IDLE,
    sdaSync: SYNC_IDLE, sclLvl: 1'b1, sdaLvl: 1'b1, default: '0};
  localparam mmts_sys_t SYS_RESET = '{state: SYS_IDLE, default: '0};

endpackage

// ==== design/mmts_twowire_slave.sv ====
// Two-wire management slave: bus engine, two byte pages, timed write cycle
`timescale 1ns/100ps
module mmts_twowire_slave #(
  parameter int unsigned WR_SHORT_CYC = mmts_pkg::TWR_SHORT_CYC,
  parameter int unsigned WR_LONG_CYC = mmts_pkg::TWR_LONG_CYC,
  parameter int unsigned HOLD_MAX_CYC = mmts_pkg::HOLD_MAX_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic linkClock,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclOut,
  output logic sclOe,
  output logic sdaOut,
  output logic sdaOe
);

  localparam int TIMER_W = mmts_pkg::TIMER_W;

  mmts_pkg::mmts_link_t q;
  mmts_pkg::mmts_link_t n;
  mmts_pkg::mmts_sys_t sq;
  mmts_pkg::mmts_sys_t sn;

  // Memory pages carry no reset: contents live on, counters restart
  logic [7:0] mem [2][256];
  logic memWe;
  logic [7:0] memAddr;
  logic [7:0] memData;
  logic [7:0] rdByte;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic busy;
  logic loadNow;
  logic addrHit;

  ////////////////////////////////////////////////////////////////////////////////
  // Link side: bus engine on the local oversampling clock

  always_comb begin
    n = q;
    loadNow = 1'b0;
    memWe = 1'b0;
    memAddr = q.wrBase + {4'h0, q.commitIdx};
    memData = q.wrBuf[q.commitIdx[2:0]];
    n.sclSync = {q.sclSync[1:0], sclIn};
    n.sdaSync = {q.sdaSync[1:0], sdaIn};
    if (q.sclSync[2] == q.sclSync[1]) begin
      n.sclLvl = q.sclSync[2];
    end
    if (q.sdaSync[2] == q.sdaSync[1]) begin
      n.sdaLvl = q.sdaSync[2];
    end
    n.ackSync = {q.ackSync[0], sq.ackToggle};
    sclRise = !q.sclLvl && n.sclLvl;
    sclFall = q.sclLvl && !n.sclLvl;
    startDet = q.sclLvl && n.sclLvl && q.sdaLvl && !n.sdaLvl;
    stopDet = q.sclLvl && n.sclLvl && !q.sdaLvl && n.sdaLvl;
    busy = q.reqToggle != q.ackSync[1];
    rdByte = mem[q.dev][q.addrCnt[q.dev]];
    addrHit = (q.shift[7:1] == mmts_pkg::FIRST_DEVICE_ADDRESS) ||
      (q.shift[7:1] == mmts_pkg::SECOND_DEVICE_ADDRESS);

    case (q.state)
      mmts_pkg::S_IDLE: begin
        n.sdaOe = 1'b0;
      end
      mmts_pkg::S_RX: begin
        if (sclRise) begin
          n.shift = {q.shift[6:0], n.sdaLvl};
          n.bitCnt = q.bitCnt + 4'h1;
        end else if (sclFall && q.bitCnt == mmts_pkg::BYTE_BITS) begin
          n.bitCnt = 4'h0;
          n.state = mmts_pkg::S_IDLE;
          case (q.kind)
            mmts_pkg::KIND_DEV: begin
              // Busy write cycle: stay silent so the host can poll
              if (addrHit && !busy) begin
                n.dev = (q.shift[7:1] == mmts_pkg::SECOND_DEVICE_ADDRESS);
                n.readOp = q.shift[0];
                n.sdaOe = 1'b1;
                n.state = mmts_pkg::S_ACK;
              end
            end
            mmts_pkg::KIND_MEM: begin
              n.addrCnt[q.dev] = q.shift;
              n.wrBase = q.shift;
              n.wrCount = 4'h0;
              n.wrPending = 1'b1;
              n.sdaOe = 1'b1;
              n.state = mmts_pkg::S_ACK;
            end
            default: begin
              if (q.wrCount < mmts_pkg::WR_MAX_BYTES) begin
                n.wrBuf[q.wrCount[2:0]] = q.shift;
                n.wrCount = q.wrCount + 4'h1;
                n.sdaOe = 1'b1;
                n.state = mmts_pkg::S_ACK;
              end
            end
          endcase
        end
      end
      mmts_pkg::S_ACK: begin
        if (sclFall) begin
          n.sdaOe = 1'b0;
          if (q.kind == mmts_pkg::KIND_DEV && q.readOp) begin
            loadNow = 1'b1;
          end else begin
            n.state = mmts_pkg::S_RX;
            n.kind = (q.kind == mmts_pkg::KIND_DEV) ? mmts_pkg::KIND_MEM :
              mmts_pkg::KIND_DATA;
          end
        end
      end
      mmts_pkg::S_STRETCH: begin
        // Short hold only; at 100 kHz the host low phase hides it entirely
        if (q.stretchCnt == mmts_pkg::STRETCH_LAST) begin
          n.sclOe = 1'b0;
          n.state = mmts_pkg::S_TX;
        end else begin
          n.stretchCnt = q.stretchCnt - 4'h1;
        end
      end
      mmts_pkg::S_TX: begin
        if (sclRise) begin
          n.bitCnt = q.bitCnt + 4'h1;
        end else if (sclFall) begin
          if (q.bitCnt == mmts_pkg::BYTE_BITS) begin
            n.sdaOe = 1'b0;
            n.bitCnt = 4'h0;
            n.hostAck = 1'b0;
            n.state = mmts_pkg::S_TXACK;
          end else begin
            n.shift = {q.shift[6:0], 1'b0};
            n.sdaOe = !q.shift[6];
          end
        end
      end
      mmts_pkg::S_TXACK: begin
        if (sclRise) begin
          n.hostAck = !n.sdaLvl;
        end else if (sclFall) begin
          if (q.hostAck) begin
            loadNow = 1'b1;
          end else begin
            n.state = mmts_pkg::S_IDLE;
          end
        end
      end
      mmts_pkg::S_COMMIT: begin
        memWe = 1'b1;
        n.commitIdx = q.commitIdx + 4'h1;
        if (q.commitIdx + 4'h1 == q.wrCount) begin
          n.addrCnt[q.dev] = q.wrBase + {4'h0, q.wrCount};
          n.wrCount = 4'h0;
          n.reqToggle = !q.reqToggle;
          n.state = mmts_pkg::S_IDLE;
        end
      end
      default: begin
        n.state = mmts_pkg::S_IDLE;
      end
    endcase

    if (loadNow) begin
      n.shift = rdByte;
      n.addrCnt[q.dev] = q.addrCnt[q.dev] + mmts_pkg::ADDR_STEP;
      n.sdaOe = !rdByte[7];
      n.sclOe = 1'b1;
      n.stretchCnt = mmts_pkg::STRETCH_LOAD;
      n.bitCnt = 4'h0;
      n.state = mmts_pkg::S_STRETCH;
    end

    // The few commit cycles finish long before the host may start again
    if (q.state != mmts_pkg::S_COMMIT) begin
      if (startDet) begin
        n.state = mmts_pkg::S_RX;
        n.kind = mmts_pkg::KIND_DEV;
        n.bitCnt = 4'h0;
        n.sdaOe = 1'b0;
        n.sclOe = 1'b0;
        n.wrPending = 1'b0;
        n.wrCount = 4'h0;
      end else if (stopDet) begin
        n.sdaOe = 1'b0;
        n.sclOe = 1'b0;
        n.wrPending = 1'b0;
        n.commitIdx = 4'h0;
        n.longWrite = q.wrCount > mmts_pkg::LONG_WRITE_BYTES;
        if (q.wrPending && q.wrCount != 4'h0) begin
          n.state = mmts_pkg::S_COMMIT;
        end else begin
          n.state = mmts_pkg::S_IDLE;
        end
      end
    end
  end

  always_ff @(posedge linkClock or posedge rst) begin
    if (rst) begin
      q <= mmts_pkg::LINK_RESET;
    end else begin
      q <= n;
    end
  end

  always_ff @(posedge linkClock) begin
    if (memWe) begin
      mem[q.dev][memAddr] <= memData;
    end
  end

  assign sclOut = q.zeroOut;
  assign sclOe = q.sclOe;
  assign sdaOut = q.zeroOut;
  assign sdaOe = q.sdaOe;

  ////////////////////////////////////////////////////////////////////////////////
  // System side: write-cycle timer on the main clock

  always_comb begin
    sn = sq;
    sn.reqSync = {sq.reqSync[0], q.reqToggle};
    sn.longSync = {sq.longSync[0], q.longWrite};
    case (sq.state)
      mmts_pkg::SYS_IDLE: begin
        if (sq.reqSync[1] != sq.ackToggle) begin
          // Length flag settled before the toggle was raised
          sn.timer = sq.longSync[1] ?
            TIMER_W'(WR_LONG_CYC - mmts_pkg::SYNC_MARGIN_CYC) :
            TIMER_W'(WR_SHORT_CYC - mmts_pkg::SYNC_MARGIN_CYC);
          sn.state = mmts_pkg::SYS_TIME;
        end
      end
      mmts_pkg::SYS_TIME: begin
        if (sq.timer == '0) begin
          sn.ackToggle = sq.reqSync[1];
          sn.state = mmts_pkg::SYS_IDLE;
        end else begin
          sn.timer = sq.timer - TIMER_W'(1);
        end
      end
      default: begin
        sn.state = mmts_pkg::SYS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sq <= mmts_pkg::SYS_RESET;
    end else begin
      sq <= sn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_devAck;
    @(posedge linkClock) disable iff (rst)
    (q.state == mmts_pkg::S_RX && q.kind == mmts_pkg::KIND_DEV && sclFall &&
      q.bitCnt == mmts_pkg::BYTE_BITS && !startDet && !stopDet) |=>
      (q.sdaOe == ($past(addrHit) && !$past(busy)));
  endproperty
  a_devAck: assert property (p_devAck) else $error("address ack wrong");

  property p_stretchLen;
    @(posedge linkClock) disable iff (rst)
    $rose(q.sclOe) |-> q.sclOe [*5] ##1 !q.sclOe;
  endproperty
  a_stretchLen: assert property (p_stretchLen) else $error("stretch length wrong");

  property p_holdLimit;
    @(posedge linkClock) disable iff (rst)
    q.sclOe |-> (q.stretchCnt <= HOLD_MAX_CYC) && q.state == mmts_pkg::S_STRETCH;
  endproperty
  a_holdLimit: assert property (p_holdLimit) else $error("clock held outside stretch");

  property p_sdaLowPhase;
    @(posedge linkClock) disable iff (rst)
    $changed(q.sdaOe) |-> !q.sclLvl || $past(startDet) || $past(stopDet);
  endproperty
  a_sdaLowPhase: assert property (p_sdaLowPhase) else $error("data moved in high phase");

  property p_startReset;
    @(posedge linkClock) disable iff (rst)
    (startDet && q.state != mmts_pkg::S_COMMIT) |=>
      q.state == mmts_pkg::S_RX && q.bitCnt == 4'h0 && q.wrCount == 4'h0 && !q.sdaOe;
  endproperty
  a_startReset: assert property (p_startReset) else $error("start did not restart");

  property p_stopEnd;
    @(posedge linkClock) disable iff (rst)
    (stopDet && q.state != mmts_pkg::S_COMMIT) |=>
      (q.state == mmts_pkg::S_IDLE || q.state == mmts_pkg::S_COMMIT) && !q.sdaOe;
  endproperty
  a_stopEnd: assert property (p_stopEnd) else $error("stop did not end");

  property p_nackRelease;
    @(posedge linkClock) disable iff (rst)
    (q.state == mmts_pkg::S_TXACK && sclFall && !q.hostAck && !startDet && !stopDet) |=>
      q.state == mmts_pkg::S_IDLE && !q.sdaOe;
  endproperty
  a_nackRelease: assert property (p_nackRelease) else $error("no release on nack");

  property p_readStep;
    @(posedge linkClock) disable iff (rst)
    loadNow |=> q.addrCnt[q.dev] == $past(q.addrCnt[q.dev]) + mmts_pkg::ADDR_STEP;
  endproperty
  a_readStep: assert property (p_readStep) else $error("read counter step wrong");

  property p_maxBytes;
    @(posedge linkClock) disable iff (rst)
    q.wrCount <= mmts_pkg::WR_MAX_BYTES;
  endproperty
  a_maxBytes: assert property (p_maxBytes) else $error("too many bytes held");

  property p_timerLoad;
    @(posedge clock) disable iff (rst)
    (sq.state == mmts_pkg::SYS_IDLE && sq.reqSync[1] != sq.ackToggle) |=>
      sq.state == mmts_pkg::SYS_TIME && sq.timer < WR_LONG_CYC;
  endproperty
  a_timerLoad: assert property (p_timerLoad) else $error("write timer load wrong");

  property p_byteLimit;
    @(posedge linkClock) disable iff (rst)
    (q.state == mmts_pkg::S_RX && q.kind == mmts_pkg::KIND_DATA && sclFall &&
      q.bitCnt == mmts_pkg::BYTE_BITS && q.wrCount == mmts_pkg::WR_MAX_BYTES) |=>
      !q.sdaOe && q.state == mmts_pkg::S_IDLE;
  endproperty
  a_byteLimit: assert property (p_byteLimit) else $error("extra byte acked");

  property p_readSelect;
    @(posedge linkClock) disable iff (rst)
    (q.state == mmts_pkg::S_RX && q.kind == mmts_pkg::KIND_DEV && sclFall &&
      q.bitCnt == mmts_pkg::BYTE_BITS && addrHit && !busy) |=>
      q.readOp == $past(q.shift[0]) && q.state == mmts_pkg::S_ACK;
  endproperty
  a_readSelect: assert property (p_readSelect) else $error("read select wrong");

endmodule

// ==== test/mmts_host_model.sv ====
// Host bus master model that clocks and starts every transfer
`timescale 1ns/100ps
module mmts_host_model (
  input wire logic clock,
  input wire logic sclWire,
  input wire logic sdaWire,
  output logic hostSclLow,
  output logic hostSdaLow,
  output logic stallSeen
);
  // 0.8 us steps keep low and high phases well above the minimum
  localparam int QTR = 20;
  localparam int BUF_CYC = 500;
  localparam int HOLD_CYC = 12500;
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hostSclLow = 1'b0;
    hostSdaLow = 1'b0;
    stallSeen = 1'b0;
  end
  task automatic pause(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Release and wait out any stretch, bounded by the hold limit
  task automatic sclHigh();
    int k;
    k = 0;
    hostSclLow = 1'b0;
    while (sclWire !== 1'b1 && k < HOLD_CYC) begin
      @(negedge clock);
      k++;
    end
    if (k >= HOLD_CYC) stallSeen = 1'b1;
    pause(QTR);
  endtask
  task automatic sclLow();
    hostSclLow = 1'b1;
    pause(QTR);
  endtask
  task automatic start();
    hostSdaLow = 1'b0;
    pause(QTR);
    sclHigh();
    pause(BUF_CYC);
    hostSdaLow = 1'b1;
    pause(QTR);
    sclLow();
  endtask
  task automatic stop();
    hostSdaLow = 1'b1;
    pause(QTR);
    sclHigh();
    hostSdaLow = 1'b0;
    pause(QTR);
  endtask
  task automatic writeByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      hostSdaLow = !b[i];
      pause(QTR);
      sclHigh();
      sclLow();
    end
    hostSdaLow = 1'b0;
    pause(QTR);
    sclHigh();
    ack = !sdaWire;
    sclLow();
  endtask
  task automatic readByte(input logic ackIt, output logic [7:0] b);
    hostSdaLow = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pause(QTR);
      sclHigh();
      b[i] = sdaWire;
      sclLow();
    end
    hostSdaLow = ackIt;
    pause(QTR);
    sclHigh();
    sclLow();
    hostSdaLow = 1'b0;
  endtask
  // Up to nine pulses, then a START once the data line is seen high
  task automatic recover(output logic seen);
    int n;
    n = 0;
    seen = 1'b0;
    hostSdaLow = 1'b0;
    while (!seen && n < 9) begin
      n++;
      pause(QTR);
      sclHigh();
      seen = (sdaWire === 1'b1);
      if (!seen) sclLow();
    end
    if (seen) begin
      hostSdaLow = 1'b1;
      pause(QTR);
      sclLow();
    end
  endtask
endmodule

// ==== test/mmts_twowire_slave_tb.sv ====
// Self-checking bench of the two-wire management slave
`timescale 1ns/100ps
module mmts_twowire_slave_tb;
  logic clock;
  logic rst;
  logic linkClock;
  logic sclOut;
  logic sclOe;
  logic sdaOut;
  logic sdaOe;
  logic hostSclLow;
  logic hostSdaLow;
  logic stallSeen;
  logic sclWire;
  logic sdaWire;
  int errTotal;
  int checked;
  int stretches;
  logic [7:0] pg0 [4] = '{8'h5a, 8'hc3, 8'h96, 8'h0f};
  logic [7:0] pg1 [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
  ////////////////////////////////////////////////////////////////////////////////
  // Wired lines: pull-up unless someone pulls low
  assign sclWire = !(sclOe | hostSclLow);
  assign sdaWire = !(sdaOe | hostSdaLow);
  mmts_twowire_slave #(.WR_SHORT_CYC(2000), .WR_LONG_CYC(4000)) i_mmts_twowire_slave (
    .clock(clock), .rst(rst), .linkClock(linkClock), .sclIn(sclWire), .sdaIn(sdaWire),
    .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe));
  mmts_host_model i_mmts_host_model (
    .clock(clock), .sclWire(sclWire), .sdaWire(sdaWire), .hostSclLow(hostSclLow),
    .hostSdaLow(hostSdaLow), .stallSeen(stallSeen));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Offset keeps the link clock out of phase with the system clock
  initial begin
    linkClock = 1'b0;
    #7;
    forever #40 linkClock = ~linkClock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic checkBit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wb(input logic [7:0] b, input logic expAck);
    logic a;
    i_mmts_host_model.writeByte(b, a);
    checkBit(a, expAck);
  endtask
  task automatic rb(input logic ackIt, input logic [7:0] exp);
    logic [7:0] b;
    i_mmts_host_model.readByte(ackIt, b);
    checkByte(b, exp);
  endtask
  // Polls with the first address until it is acknowledged
  task automatic poll(output int tries);
    logic a;
    a = 1'b0;
    tries = 0;
    while (!a && tries < 10) begin
      tries++;
      i_mmts_host_model.start();
      i_mmts_host_model.writeByte(8'ha0, a);
      i_mmts_host_model.stop();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic testReset();
    checkBit(sdaOe, 1'b0);
    checkBit(sclOe, 1'b0);
    checkBit(sdaOut, 1'b0);
    checkBit(sclOut, 1'b0);
    $display("test reset finished");
  endtask
  task automatic testWrite();
    int tries;
    i_mmts_host_model.start();
    wb(8'ha0, 1'b1);
    wb(8'h10, 1'b1);
    for (int i = 0; i < 4; i++) wb(pg0[i], 1'b1);
    i_mmts_host_model.stop();
    poll(tries);
    checkBit(tries > 1, 1'b1);
    checkBit(tries <= 3, 1'b1);
    $display("test write finished");
  endtask
  task automatic testRead();
    int s0;
    s0 = stretches;
    i_mmts_host_model.start();
    wb(8'ha0, 1'b1);
    wb(8'h10, 1'b1);
    i_mmts_host_model.start();
    wb(8'ha1, 1'b1);
    rb(1'b1, pg0[0]);
    rb(1'b1, pg0[1]);
    rb(1'b0, pg0[2]);
    checkBit(sdaOe, 1'b0);
    checkBit(stretches - s0 == 3, 1'b1);
    i_mmts_host_model.stop();
    $display("test read finished");
  endtask
  // Host stalls mid-read while the slave drives low bits
  task automatic testRecover();
    logic seen;
    i_mmts_host_model.start();
    wb(8'ha1, 1'b1);
    i_mmts_host_model.recover(seen);
    checkBit(seen, 1'b1);
    wb(8'ha0, 1'b1);
    i_mmts_host_model.stop();
    $display("test recover finished");
  endtask
  task automatic testAbort();
    i_mmts_host_model.start();
    wb(8'ha0, 1'b1);
    wb(8'h10, 1'b1);
    wb(8'h00, 1'b1);
    i_mmts_host_model.start();
    wb(8'ha1, 1'b1);
    rb(1'b0, pg0[0]);
    i_mmts_host_model.stop();
    $display("test abort finished");
  endtask
  task automatic testPage1();
    int tries;
    i_mmts_host_model.start();
    wb(8'ha2, 1'b1);
    wb(8'hff, 1'b1);
    for (int i = 0; i < 5; i++) wb(pg1[i], 1'b1);
    i_mmts_host_model.stop();
    poll(tries);
    checkBit(tries <= 5, 1'b1);
    i_mmts_host_model.start();
    wb(8'ha2, 1'b1);
    wb(8'hff, 1'b1);
    i_mmts_host_model.start();
    wb(8'ha3, 1'b1);
    rb(1'b1, pg1[0]);
    rb(1'b1, pg1[1]);
    rb(1'b0, pg1[2]);
    i_mmts_host_model.stop();
    i_mmts_host_model.start();
    wb(8'ha1, 1'b1);
    rb(1'b0, pg0[1]);
    i_mmts_host_model.stop();
    $display("test page1 finished");
  endtask
  task automatic testUnknown();
    i_mmts_host_model.start();
    wb(8'ha4, 1'b0);
    i_mmts_host_model.stop();
    $display("test unknown finished");
  endtask
  // Eight bytes land, the ninth is refused, long write time applies
  task automatic testOverflow();
    int tries;
    i_mmts_host_model.start();
    wb(8'ha2, 1'b1);
    wb(8'h20, 1'b1);
    for (int i = 0; i < 8; i++) wb(8'h80 + 8'(i), 1'b1);
    wb(8'hee, 1'b0);
    i_mmts_host_model.stop();
    poll(tries);
    checkBit(tries > 2 && tries <= 5, 1'b1);
    i_mmts_host_model.start();
    wb(8'ha2, 1'b1);
    wb(8'h26, 1'b1);
    i_mmts_host_model.start();
    wb(8'ha3, 1'b1);
    rb(1'b1, 8'h86);
    rb(1'b0, 8'h87);
    i_mmts_host_model.stop();
    $display("test overflow finished");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sclOe) stretches++;
  always @(posedge stallSeen) begin
    errTotal++;
    printVerdict();
  end
  initial begin
    #4000000;
    errTotal++;
    printVerdict();
  end
  initial begin
    errTotal = 0;
    checked = 0;
    rst = 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    repeat (10) @(negedge clock);
    testReset();
    testWrite();
    testRead();
    testRecover();
    testAbort();
    testPage1();
    testUnknown();
    testOverflow();
    printVerdict();
  end
endmodule
